// ===== rtl/scg_cfg.svh
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH

`define SCG_NUM_CLK 10
`define SCG_CNT_W 4
`define SCG_ADDR_W 4

`define SCG_OFF_CLK_CTRL 4'h0
`define SCG_OFF_BRIDGE_CTRL 4'h4
`define SCG_OFF_PM_CTRL 4'h8
`define SCG_OFF_STATUS 4'hc

`define SCG_BRG_SEC_RST_BIT 0
`define SCG_PM_STATE_LSB 0
`define SCG_PM_STATE_W 2
`define SCG_PM_D3HOT 2'h3

`define SCG_ST_CAPTURED_BIT 0
`define SCG_ST_SPEED66_BIT 1
`define SCG_ST_MODE_RSVD_BIT 2
`define SCG_ST_PARKED_LOW_BIT 3
`define SCG_ST_TEST_MODE_BIT 4
`define SCG_ST_FEEDBACK_BIT 5

`define SCG_CLK_CTRL_RST 10'h000
`define SCG_BRG_CTRL_RST 1'h0
`define SCG_PM_CTRL_RST 2'h0

`define SCG_MODE_NORMAL_LO 1'h1
`define SCG_MODE_NORMAL_HI 1'h0

`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_DECERR 2'h3

`define SCG_PIN_W 7
`endif

// ===== rtl/scg_pin_if.sv
interface scg_pin_if;
    logic primary_reset_n;
    logic clock_mask_serial_in;
    logic bus_power_clock_strap;
    logic speed_select_strap;
    logic mode_select_lo;
    logic mode_select_hi;
    logic secondary_clock_feedback;

    modport filter (
        output primary_reset_n, clock_mask_serial_in, bus_power_clock_strap,
        output speed_select_strap, mode_select_lo, mode_select_hi,
        output secondary_clock_feedback
    );
    modport core (
        input primary_reset_n, clock_mask_serial_in, bus_power_clock_strap,
        input speed_select_strap, mode_select_lo, mode_select_hi,
        input secondary_clock_feedback
    );
endinterface

// ===== rtl/scg_pin_sync.sv
`include "scg_cfg.svh"

module scg_pin_sync
    import scg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw pins
    input wire logic [`SCG_PIN_W-1:0] pins_raw,
    // Filtered levels
    scg_pin_if.filter pins
);
    logic [`SCG_PIN_W-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [`SCG_PIN_W-1:0] s1_d, s2_d, s3_d, filt_d;

    // Level accepted once stages two and three agree
    always_comb begin
        s1_d = pins_raw;
        s2_d = s1_q;
        s3_d = s2_q;
        filt_d = filt_q;
        for (int i = 0; i < `SCG_PIN_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    // Reset value treats primary reset as asserted
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
            s3_q <= 7'h00;
            filt_q <= 7'h00;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            filt_q <= filt_d;
        end
    end

    assign pins.primary_reset_n = filt_q[0];
    assign pins.clock_mask_serial_in = filt_q[1];
    assign pins.bus_power_clock_strap = filt_q[2];
    assign pins.speed_select_strap = filt_q[3];
    assign pins.mode_select_lo = filt_q[4];
    assign pins.mode_select_hi = filt_q[5];
    assign pins.secondary_clock_feedback = filt_q[6];
endmodule

// ===== rtl/scg_pkg.sv
package scg_pkg;
    typedef enum logic [2:0] {
        SCG_IN_RESET = 3'h1,
        SCG_CAPTURE = 3'h2,
        SCG_RUN = 3'h4
    } scg_state_t;

    typedef logic [9:0] scg_clk_vec_t;
endpackage

// ===== rtl/scg_top.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`include "scg_cfg.svh"

module scg_top
    import scg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pins
    input wire logic primary_reset_n,
    input wire logic clock_mask_serial_in,
    input wire logic bus_power_clock_strap,
    input wire logic speed_select_strap,
    input wire logic mode_select_lo,
    input wire logic mode_select_hi,
    input wire logic test_mode,
    input wire logic secondary_clock_feedback,
    // Secondary side
    output logic [9:0] secondary_clock_out,
    output logic secondary_reset_n,
    output logic speed_66mhz_en,
    output logic scan_shift_en,
    output logic scan_capture_en,
    // AXI4-Lite slave
    input wire logic [`SCG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SCG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    scg_pin_if pins ();

    scg_pin_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins_raw({secondary_clock_feedback, mode_select_hi, mode_select_lo,
                   speed_select_strap, bus_power_clock_strap,
                   clock_mask_serial_in, primary_reset_n}),
        .pins(pins.filter)
    );

    function automatic logic addr_hit(input logic [`SCG_ADDR_W-1:0] a,
                                      input logic [`SCG_ADDR_W-1:0] off);
        addr_hit = (a[`SCG_ADDR_W-1:2] == off[`SCG_ADDR_W-1:2]);
    endfunction

    // Capture state
    scg_state_t state_q, state_d;
    logic [`SCG_CNT_W-1:0] cnt_q, cnt_d;
    scg_clk_vec_t clk_ctrl_q, clk_ctrl_d;
    logic speed66_q, speed66_d;
    logic captured_q, captured_d;
    logic gate_high_q, gate_high_d;
    logic [9:0] park_high_q, park_high_d;
    logic park_low_q, park_low_d;
    logic sec_rst_q, sec_rst_d;
    logic scan_shift_q, scan_shift_d;
    logic scan_cap_q, scan_cap_d;
    // Software state
    logic brg_rst_q, brg_rst_d;
    logic [`SCG_PM_STATE_W-1:0] pm_state_q, pm_state_d;
    // Bus state
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [`SCG_ADDR_W-1:0] awaddr_q, awaddr_d, araddr_w;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic do_write;
    logic [31:0] status_w;

    assign araddr_w = s_axi_araddr;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`SCG_ST_CAPTURED_BIT] = captured_q;
        status_w[`SCG_ST_SPEED66_BIT] = speed66_q;
        status_w[`SCG_ST_MODE_RSVD_BIT] = !(pins.mode_select_lo == `SCG_MODE_NORMAL_LO &&
                                            pins.mode_select_hi == `SCG_MODE_NORMAL_HI);
        status_w[`SCG_ST_PARKED_LOW_BIT] = park_low_q;
        status_w[`SCG_ST_TEST_MODE_BIT] = test_mode;
        status_w[`SCG_ST_FEEDBACK_BIT] = pins.secondary_clock_feedback;
    end

    // Capture and gating
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        clk_ctrl_d = clk_ctrl_q;
        speed66_d = speed66_q;
        captured_d = captured_q;
        brg_rst_d = brg_rst_q;
        pm_state_d = pm_state_q;
        if (do_write && addr_hit(awaddr_q, `SCG_OFF_CLK_CTRL)) begin
            if (wstrb_q[0]) begin
                clk_ctrl_d[7:0] = wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                clk_ctrl_d[9:8] = wdata_q[9:8];
            end
        end
        if (do_write && addr_hit(awaddr_q, `SCG_OFF_BRIDGE_CTRL) && wstrb_q[0]) begin
            brg_rst_d = wdata_q[`SCG_BRG_SEC_RST_BIT];
        end
        if (do_write && addr_hit(awaddr_q, `SCG_OFF_PM_CTRL) && wstrb_q[0]) begin
            pm_state_d = wdata_q[`SCG_PM_STATE_LSB +: `SCG_PM_STATE_W];
        end
        unique case (state_q)
            SCG_IN_RESET: begin
                cnt_d = 4'h0;
                clk_ctrl_d = `SCG_CLK_CTRL_RST;
                brg_rst_d = `SCG_BRG_CTRL_RST;
                pm_state_d = `SCG_PM_CTRL_RST;
                captured_d = 1'b0;
                if (pins.primary_reset_n && sec_rst_q) begin
                    state_d = SCG_CAPTURE;
                    speed66_d = pins.speed_select_strap;
                end
            end
            SCG_CAPTURE: begin
                clk_ctrl_d = {pins.clock_mask_serial_in, clk_ctrl_q[9:1]};
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(`SCG_NUM_CLK - 1)) begin
                    state_d = SCG_RUN;
                    captured_d = 1'b1;
                end
            end
            SCG_RUN: begin
                speed66_d = pins.speed_select_strap;
            end
        endcase
        if (!pins.primary_reset_n) begin
            state_d = SCG_IN_RESET;
        end
    end

    // Output stage
    always_comb begin
        sec_rst_d = !pins.primary_reset_n || brg_rst_q || state_q != SCG_RUN;
        gate_high_d = captured_q && state_q == SCG_RUN;
        park_high_d = gate_high_q ? clk_ctrl_q : 10'h000;
        park_low_d = pins.bus_power_clock_strap && pm_state_q == `SCG_PM_D3HOT;
        scan_shift_d = test_mode && !pins.speed_select_strap;
        scan_cap_d = test_mode && pins.speed_select_strap;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= SCG_IN_RESET;
            cnt_q <= 4'h0;
            clk_ctrl_q <= `SCG_CLK_CTRL_RST;
            speed66_q <= 1'b0;
            captured_q <= 1'b0;
            gate_high_q <= 1'b0;
            park_high_q <= 10'h000;
            park_low_q <= 1'b0;
            sec_rst_q <= 1'b1;
            scan_shift_q <= 1'b0;
            scan_cap_q <= 1'b0;
            brg_rst_q <= `SCG_BRG_CTRL_RST;
            pm_state_q <= `SCG_PM_CTRL_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            clk_ctrl_q <= clk_ctrl_d;
            speed66_q <= speed66_d;
            captured_q <= captured_d;
            gate_high_q <= gate_high_d;
            park_high_q <= park_high_d;
            park_low_q <= park_low_d;
            sec_rst_q <= sec_rst_d;
            scan_shift_q <= scan_shift_d;
            scan_cap_q <= scan_cap_d;
            brg_rst_q <= brg_rst_d;
            pm_state_q <= pm_state_d;
        end
    end

    // Gates only change at a rising edge, so parking high never glitches; parking low
    // may shorten the last high phase.
    always_comb begin
        for (int i = 0; i < `SCG_NUM_CLK; i++) begin
            secondary_clock_out[i] = (clk | park_high_q[i]) & !park_low_q;
        end
    end

    assign secondary_reset_n = !sec_rst_q;
    assign speed_66mhz_en = speed66_q;
    assign scan_shift_en = scan_shift_q;
    assign scan_capture_en = scan_cap_q;

    // AXI4-Lite slave
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (addr_hit(awaddr_q, `SCG_OFF_CLK_CTRL) ||
                       addr_hit(awaddr_q, `SCG_OFF_BRIDGE_CTRL) ||
                       addr_hit(awaddr_q, `SCG_OFF_PM_CTRL) ||
                       addr_hit(awaddr_q, `SCG_OFF_STATUS)) ? `SCG_RESP_OKAY : `SCG_RESP_DECERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = `SCG_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (addr_hit(araddr_w, `SCG_OFF_CLK_CTRL)) begin
                rdata_d[9:0] = clk_ctrl_q;
            end else if (addr_hit(araddr_w, `SCG_OFF_BRIDGE_CTRL)) begin
                rdata_d[`SCG_BRG_SEC_RST_BIT] = brg_rst_q;
            end else if (addr_hit(araddr_w, `SCG_OFF_PM_CTRL)) begin
                rdata_d[`SCG_PM_STATE_LSB +: `SCG_PM_STATE_W] = pm_state_q;
            end else if (addr_hit(araddr_w, `SCG_OFF_STATUS)) begin
                rdata_d = status_w;
            end else begin
                rresp_d = `SCG_RESP_DECERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

// ===== tb/scg_checker.sv
module scg_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched ports
    input wire logic primary_reset_n,
    input wire logic bus_power_clock_strap,
    input wire logic speed_select_strap,
    input wire logic test_mode,
    input wire logic [9:0] secondary_clock_out,
    input wire logic secondary_reset_n,
    input wire logic speed_66mhz_en,
    input wire logic scan_shift_en,
    input wire logic scan_capture_en,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_arready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_sec_rst; !primary_reset_n [*8] |-> !secondary_reset_n; endproperty
    a_sec_rst: assert property (p_sec_rst) else $error("sec reset free");
    property p_start; $rose(secondary_reset_n) |-> $past(primary_reset_n, 15); endproperty
    a_start: assert property (p_start) else $error("capture too short");
    property p_speed;
        (secondary_reset_n && !test_mode && $stable(speed_select_strap)) [*8]
            |-> speed_66mhz_en == speed_select_strap;
    endproperty
    a_speed: assert property (p_speed) else $error("speed mismatch");
    property p_scan;
        (test_mode && $stable(speed_select_strap)) [*8]
            |-> scan_capture_en == speed_select_strap && scan_shift_en != speed_select_strap;
    endproperty
    a_scan: assert property (p_scan) else $error("scan mismatch");
    property p_scan_off; !test_mode |=> !scan_shift_en && !scan_capture_en; endproperty
    a_scan_off: assert property (p_scan_off) else $error("scan outside test");
    // High phase sampled at the falling edge
    property p_no_low;
        @(negedge clk) disable iff (sys_rst)
            !bus_power_clock_strap [*8] |-> secondary_clock_out == 10'h3ff;
    endproperty
    a_no_low: assert property (p_no_low) else $error("clock stopped low");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    c_capture: cover property ($rose(secondary_reset_n));
    c_scan: cover property (scan_capture_en);
    c_park: cover property (bus_power_clock_strap && secondary_reset_n);
endmodule

bind scg_top scg_checker chk_u (.clk, .sys_rst, .primary_reset_n, .bus_power_clock_strap,
    .speed_select_strap, .test_mode, .secondary_clock_out, .secondary_reset_n,
    .speed_66mhz_en, .scan_shift_en, .scan_capture_en, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_arready);

// ===== tb/scg_far_side.sv
module scg_far_side (
    // Clock and capture window
    input wire logic clk,
    input wire logic secondary_reset_n,
    input wire logic mask_level,
    input wire logic [9:0] secondary_clock_out,
    // Pins toward the block
    output logic clock_mask_serial_in,
    output logic secondary_clock_feedback
);
    timeunit 1ns;
    timeprecision 1ns;
    logic churn_q = 1'b0;

    // Mask pin churns once the capture window has closed
    always @(posedge clk) churn_q <= ~churn_q;
    assign clock_mask_serial_in = secondary_reset_n ? churn_q : mask_level;
    assign secondary_clock_feedback = secondary_clock_out[0];
endmodule

// ===== tb/secondary_clock_gating_straps_bench.sv
module secondary_clock_gating_straps_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1, primary_reset_n = 1'b0, mask_level = 1'b0;
    logic bus_power_clock_strap = 1'b0, speed_select_strap = 1'b0, test_mode = 1'b0;
    logic mode_select_lo = 1'b1, mode_select_hi = 1'b0;
    logic clock_mask_serial_in, secondary_clock_feedback, secondary_reset_n;
    logic [9:0] secondary_clock_out;
    logic speed_66mhz_en, scan_shift_en, scan_capture_en;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_bresp;
    int num_errors = 0, cmp_count = 0, cycles = 0;

    scg_top dut_u (.clk, .sys_rst, .primary_reset_n, .clock_mask_serial_in,
        .bus_power_clock_strap, .speed_select_strap, .mode_select_lo, .mode_select_hi,
        .test_mode, .secondary_clock_feedback, .secondary_clock_out, .secondary_reset_n,
        .speed_66mhz_en, .scan_shift_en, .scan_capture_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    scg_far_side far_u (.clk, .secondary_reset_n, .mask_level, .secondary_clock_out,
        .clock_mask_serial_in, .secondary_clock_feedback);

    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    function automatic logic [9:0] exp_out(input logic [9:0] park, input logic d3, input logic ph);
        return d3 ? 10'h000 : (ph ? 10'h3ff : park);
    endfunction

    // Low phase seen after the falling edge, high phase after the rising one
    task automatic chk_clk(input logic [9:0] park, input logic d3);
        @(negedge clk);
        #1;
        chk("clk low", {22'h0, exp_out(park, d3, 1'b0)}, {22'h0, secondary_clock_out});
        @(posedge clk);
        #1;
        chk("clk high", {22'h0, exp_out(park, d3, 1'b1)}, {22'h0, secondary_clock_out});
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        last_bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic capture(input logic lvl);
        @(posedge clk);
        primary_reset_n <= 1'b0;
        mask_level <= lvl;
        repeat (8) @(posedge clk);
        primary_reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk_clk(10'h000, 1'b0);
        for (int i = 0; i < 40 && !secondary_reset_n; i++) @(posedge clk);
        #1;
        chk("capture end", 32'h1, 32'(secondary_reset_n));
    endtask

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [9:0] m;
        void'($urandom(94));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("sec reset", 32'h0, 32'(secondary_reset_n));
        for (int k = 0; k < 2; k++) begin
            capture(k[0]);
            m = k[0] ? 10'h3ff : 10'h000;
            axi_rd(4'h0, v, r);
            chk("mask reg", {22'h0, m}, v);
            chk_clk(m, 1'b0);
        end
        axi_rd(4'hc, v, r);
        chk("capture done", 32'h1, v & 32'h1);
        for (int k = 0; k < 4; k++) begin
            m = 10'($urandom);
            axi_wr(4'h0, {22'h0, m});
            axi_rd(4'h0, v, r);
            chk("clk ctrl", {22'h0, m}, v);
            chk_clk(m, 1'b0);
        end
        axi_wr(4'h8, 32'h3);
        repeat (8) @(posedge clk);
        chk_clk(m, 1'b0);
        @(posedge clk);
        bus_power_clock_strap <= 1'b1;
        repeat (8) @(posedge clk);
        chk_clk(m, 1'b1);
        @(posedge clk);
        bus_power_clock_strap <= 1'b0;
        axi_wr(4'h8, 32'h0);
        axi_wr(4'h4, 32'h1);
        chk("wr resp", 32'h0, {30'h0, last_bresp});
        repeat (2) @(posedge clk);
        #1;
        chk("bridge hold", 32'h0, 32'(secondary_reset_n));
        axi_wr(4'h4, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk("bridge free", 32'h1, 32'(secondary_reset_n));
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            test_mode <= k[1];
            speed_select_strap <= k[0];
            repeat (10) @(posedge clk);
            #1;
            if (!k[1]) chk("speed", 32'(k[0]), 32'(speed_66mhz_en));
            chk("scan", 32'(k[1] ? (k[0] ? 2 : 1) : 0), {30'h0, scan_capture_en, scan_shift_en});
        end
        @(posedge clk);
        test_mode <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            {mode_select_hi, mode_select_lo} <= 2'(k);
            repeat (6) @(posedge clk);
            axi_rd(4'hc, v, r);
            chk("mode code", 32'(k != 1), {31'h0, v[2]});
        end
        mode_select_hi <= 1'b0;
        axi_rd(4'h6, v, r);
        chk("alias resp", 32'h0, {30'h0, r});
        chk("alias data", 32'h0, v);
        close_out();
    end
endmodule
